// File: src/fpsp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpsp_regs.svh"

module fpsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // fpsp_fifo

module fpsp_top
    import fpsp_pkg::*;
#(
    parameter int PAGE_CYCLES = `FPSP_PAGE_CYCLES,
    parameter int MASS_CYCLES = `FPSP_MASS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // device pins
    input wire logic program_enable_n,
    input wire logic device_reset_n,
    // serial programming port
    input wire logic prog_port_select_n,
    input wire logic prog_port_serial_clock,
    input wire logic prog_port_mosi,
    output logic prog_port_miso,
    output logic prog_port_miso_oe_n,
    // flash array
    output logic [1:0] flash_cmd_r,
    output logic [23:0] flash_addr_r,
    output logic [31:0] flash_wdata_r,
    output logic flash_start_r,
    input wire logic flash_done,
    // fetch stall and mode
    output logic [1:0] bank_busy_r,
    output logic prog_mode_r
);
    localparam logic [19:0] WRITE_LIM = 20'(`FPSP_WRITE_CYCLES);
    localparam logic [19:0] PAGE_LIM = 20'(PAGE_CYCLES);
    localparam logic [19:0] MASS_LIM = 20'(MASS_CYCLES);

    function automatic logic [19:0] op_limit(input fpsp_op_type op);
        case (op)
            FPSP_OP_WRITE: op_limit = WRITE_LIM;
            FPSP_OP_PAGE: op_limit = PAGE_LIM;
            default: op_limit = MASS_LIM;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [4:0] p1_r;
    logic [4:0] p2_r;
    logic [4:0] p3_r;
    logic [4:0] pf_r;
    logic en_f;
    logic rst_f;
    logic sel_f;
    logic sck_f;
    logic mosi_f;
    logic sck_prev_r;
    logic sel_prev_r;

    assign {en_f, rst_f, sel_f, sck_f, mosi_f} = pf_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            p1_r <= 5'h1c;
            p2_r <= 5'h1c;
            p3_r <= 5'h1c;
            pf_r <= 5'h1c;
        end else begin
            p1_r <= {program_enable_n, device_reset_n, prog_port_select_n,
                     prog_port_serial_clock, prog_port_mosi};
            p2_r <= p1_r;
            p3_r <= p2_r;
            for (int i = 0; i < 5; i++) begin
                if (p2_r[i] == p3_r[i]) begin
                    pf_r[i] <= p3_r[i];
                end
            end
        end
    end

    // ----------------------------------------
    // programming mode
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_mode_r <= 1'b0;
        end else if (!rst_f && !en_f) begin
            prog_mode_r <= 1'b1; // [R8] [R1]
        end else if (rst_f && en_f) begin
            prog_mode_r <= 1'b0; // [R8] [R3]
        end
    end

    // ----------------------------------------
    // serial slave
    // ----------------------------------------
    logic [63:0] shift_r;
    logic [6:0] bit_cnt_r;
    logic [7:0] stat_sh_r;
    logic frame;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic push_valid_r;
    logic [57:0] push_data_r;
    logic push_ready;
    logic overflow_r;
    logic timeout_r;
    logic busy_r;

    assign frame = prog_mode_r && !sel_f; // [R2]
    assign sck_rise = frame && sck_f && !sck_prev_r;
    assign sck_fall = frame && !sck_f && sck_prev_r;
    assign frame_end = prog_mode_r && sel_f && !sel_prev_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_prev_r <= 1'b0;
            sel_prev_r <= 1'b1;
            shift_r <= '0;
            bit_cnt_r <= '0;
        end else begin
            sck_prev_r <= sck_f;
            sel_prev_r <= sel_f;
            if (!frame) begin
                bit_cnt_r <= '0;
            end else if (sck_rise) begin
                shift_r <= {shift_r[62:0], mosi_f};
                if (bit_cnt_r != 7'h40) begin
                    bit_cnt_r <= bit_cnt_r + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat_sh_r <= '0;
            prog_port_miso <= 1'b0;
            prog_port_miso_oe_n <= 1'b1;
        end else begin
            prog_port_miso_oe_n <= !frame;
            if (sck_rise && bit_cnt_r == 7'h07 && {shift_r[6:0], mosi_f} == `FPSP_OPC_STATUS) begin
                stat_sh_r <= {5'h00, timeout_r, overflow_r | !push_ready, busy_r};
            end else if (sck_fall) begin
                prog_port_miso <= stat_sh_r[7];
                stat_sh_r <= {stat_sh_r[6:0], 1'b0};
            end
        end
    end

    // command capture, held until the fifo takes it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            push_valid_r <= 1'b0;
            push_data_r <= '0;
            overflow_r <= 1'b0;
        end else begin
            if (push_valid_r && push_ready) begin
                push_valid_r <= 1'b0;
            end
            if (frame_end && !(push_valid_r && !push_ready)) begin
                if (bit_cnt_r == 7'h40 && shift_r[63:56] == `FPSP_OPC_WRITE) begin
                    push_valid_r <= 1'b1;
                    push_data_r <= {FPSP_OP_WRITE, shift_r[55:0]};
                end else if (bit_cnt_r == 7'h20 && shift_r[31:24] == `FPSP_OPC_PAGE) begin
                    push_valid_r <= 1'b1;
                    push_data_r <= {FPSP_OP_PAGE, shift_r[23:0], 32'h0};
                end else if (bit_cnt_r == 7'h08 && shift_r[7:0] == `FPSP_OPC_MASS) begin
                    push_valid_r <= 1'b1;
                    push_data_r <= {FPSP_OP_MASS, 24'h0, 32'h0};
                end
            end else if (frame_end) begin
                overflow_r <= 1'b1;
            end else if (!prog_mode_r) begin
                overflow_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // command queue and flash engine
    // ----------------------------------------
    logic q_valid;
    logic q_ready;
    logic [57:0] q_data;
    fpsp_eng_type eng_r;
    logic [19:0] cnt_r;
    logic [19:0] lim_r;
    logic op_bank_r;

    fpsp_fifo #(.W(`FPSP_ENTRY_W), .D(`FPSP_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(push_valid_r),
        .in_ready(push_ready),
        .in_data(push_data_r),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    assign q_ready = (eng_r == FPSP_ENG_IDLE);
    assign busy_r = (eng_r != FPSP_ENG_IDLE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eng_r <= FPSP_ENG_IDLE;
            cnt_r <= '0;
            lim_r <= '0;
            op_bank_r <= 1'b0;
            flash_cmd_r <= FPSP_OP_NONE;
            flash_addr_r <= '0;
            flash_wdata_r <= '0;
            flash_start_r <= 1'b0;
            bank_busy_r <= 2'h0;
            timeout_r <= 1'b0;
        end else begin
            flash_start_r <= 1'b0;
            case (eng_r)
                FPSP_ENG_IDLE: begin
                    if (q_valid) begin
                        eng_r <= FPSP_ENG_START;
                        flash_cmd_r <= q_data[57:56];
                        flash_addr_r <= q_data[55:32];
                        flash_wdata_r <= q_data[31:0];
                        lim_r <= op_limit(fpsp_op_type'(q_data[57:56]));
                        op_bank_r <= q_data[32+`FPSP_BANK_BIT];
                        cnt_r <= '0;
                    end
                end
                FPSP_ENG_START: begin
                    eng_r <= FPSP_ENG_BUSY;
                    flash_start_r <= 1'b1;
                    bank_busy_r <= (flash_cmd_r == FPSP_OP_MASS) ? 2'h3 :
                                   (op_bank_r ? 2'h2 : 2'h1); // [R7]
                    cnt_r <= 20'h00001;
                end
                FPSP_ENG_BUSY: begin
                    cnt_r <= cnt_r + 20'h00001;
                    if (flash_done || cnt_r >= lim_r) begin // [R4] [R5] [R6]
                        eng_r <= FPSP_ENG_IDLE;
                        bank_busy_r <= 2'h0; // [R7]
                        if (!flash_done) begin
                            timeout_r <= 1'b1;
                        end
                    end
                end
                default: eng_r <= FPSP_ENG_IDLE;
            endcase
            if (!prog_mode_r && !busy_r) begin
                timeout_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_enter;
        !rst_f && !en_f;
    endsequence
    sequence s_leave;
        rst_f && en_f;
    endsequence

    AST_WRITE_BOUND: assert property (@(posedge clk) disable iff (reset) // [R4]
        (eng_r == FPSP_ENG_BUSY && flash_cmd_r == FPSP_OP_WRITE) |-> cnt_r <= WRITE_LIM)
        else $error("word write ran past its time");
    AST_PAGE_BOUND: assert property (@(posedge clk) disable iff (reset) // [R5]
        (eng_r == FPSP_ENG_BUSY && flash_cmd_r == FPSP_OP_PAGE) |-> cnt_r <= PAGE_LIM)
        else $error("page erase ran past its time");
    AST_MASS_BOUND: assert property (@(posedge clk) disable iff (reset) // [R6]
        (eng_r == FPSP_ENG_BUSY && flash_cmd_r == FPSP_OP_MASS) |-> cnt_r <= MASS_LIM)
        else $error("mass erase ran past its time");
    AST_STALL_BANK: assert property (@(posedge clk) disable iff (reset) // [R7]
        (eng_r == FPSP_ENG_BUSY) |-> bank_busy_r[op_bank_r])
        else $error("busy bank not stalled");
    AST_STALL_FREE: assert property (@(posedge clk) disable iff (reset) // [R7]
        (eng_r == FPSP_ENG_IDLE) |-> bank_busy_r == 2'h0)
        else $error("idle bank still stalled");
    AST_ENTER: assert property (@(posedge clk) disable iff (reset) // [R8]
        s_enter |=> prog_mode_r)
        else $error("mode not entered");
    AST_LEAVE: assert property (@(posedge clk) disable iff (reset) // [R8]
        s_leave |=> !prog_mode_r)
        else $error("mode not left");
    AST_MISO_IDLE: assert property (@(posedge clk) disable iff (reset) // [R8]
        !prog_mode_r |=> prog_port_miso_oe_n)
        else $error("miso driven outside mode");
endmodule // fpsp_top
`default_nettype wire

// File: common/fpsp_regs.svh
// Function
// R1: programmer asserts enable before device reset
// R2: wait 125 us after reset before select
// R3: wait 10 us before releasing reset, enable
// R4: word write completes within 21 us
// R5: page erase completes within 21 ms
// R6: bank mass erase completes within 21 ms
// R7: stall fetches from a busy bank
// R8: enter mode on enable during reset
`ifndef FPSP_REGS_SVH
`define FPSP_REGS_SVH
`define FPSP_CLK_MHZ 25
`define FPSP_T_ENTER_US 125
`define FPSP_T_EXIT_US 10
`define FPSP_T_WRITE_US 21
`define FPSP_T_PAGE_ERASE_MS 21
`define FPSP_T_MASS_ERASE_MS 21
`define FPSP_WRITE_CYCLES (`FPSP_T_WRITE_US * `FPSP_CLK_MHZ)
`define FPSP_PAGE_CYCLES (`FPSP_T_PAGE_ERASE_MS * 1000 * `FPSP_CLK_MHZ)
`define FPSP_MASS_CYCLES (`FPSP_T_MASS_ERASE_MS * 1000 * `FPSP_CLK_MHZ)
`define FPSP_OPC_WRITE 8'h02
`define FPSP_OPC_PAGE 8'h20
`define FPSP_OPC_MASS 8'hc7
`define FPSP_OPC_STATUS 8'h05
`define FPSP_BANK_BIT 18
`define FPSP_FIFO_DEPTH 8
`define FPSP_ENTRY_W 58
`define FPSP_CNT_W 20
`endif

// File: common/fpsp_pkg.sv
package fpsp_pkg;
    typedef enum logic [1:0] {
        FPSP_OP_NONE = 2'h0,
        FPSP_OP_WRITE = 2'h1,
        FPSP_OP_MASS = 2'h2,
        FPSP_OP_PAGE = 2'h3
    } fpsp_op_type;
    typedef enum logic [1:0] {
        FPSP_ENG_IDLE = 2'h0,
        FPSP_ENG_START = 2'h1,
        FPSP_ENG_BUSY = 2'h3
    } fpsp_eng_type;
endpackage

// File: verification/fpsp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

module fpsp_prog_model (
    // clock
    input wire logic clk,
    // device pins
    output logic program_enable_n,
    output logic device_reset_n,
    // serial port
    output logic prog_port_select_n,
    output logic prog_port_serial_clock,
    output logic prog_port_mosi,
    input wire logic prog_port_miso,
    input wire logic prog_port_miso_oe_n
);
    // a released line reads as the inverse of the last driven bit
    wire logic miso_line;
    logic [63:0] rx_bits;

    assign miso_line = prog_port_miso_oe_n ? ~prog_port_miso : prog_port_miso;

    initial begin
        rx_bits = '0;
        program_enable_n = 1'b1;
        device_reset_n = 1'b1;
        prog_port_select_n = 1'b1;
        prog_port_serial_clock = 1'b0;
        prog_port_mosi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // enable first, then reset, then the entry wait
    task automatic enter_mode();
        program_enable_n <= 1'b0;
        tick(1);
        device_reset_n <= 1'b0;
        tick(125 * 25);
    endtask

    task automatic leave_mode();
        tick(10 * 25);
        program_enable_n <= 1'b1;
        device_reset_n <= 1'b1;
        tick(1);
    endtask

    // mode 0 frame, msb first, clock still outside frames, miso taken before each fall
    task automatic send_frame(input logic [63:0] bits, input int n);
        prog_port_select_n <= 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            prog_port_mosi <= bits[i];
            tick(4);
            prog_port_serial_clock <= 1'b1;
            tick(4);
            rx_bits <= {rx_bits[62:0], miso_line};
            prog_port_serial_clock <= 1'b0;
        end
        tick(4);
        prog_port_select_n <= 1'b1;
        prog_port_mosi <= ~prog_port_mosi;
        tick(1);
    endtask
endmodule // fpsp_prog_model

`default_nettype wire

// File: verification/fpsp_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module fpsp_top_tb_top
    import fpsp_pkg::*;
;
    localparam int SIM_CYC = 600;
    logic clk, reset, flash_done, en_n, rst_n, sel_n, sck, mosi, miso, miso_oe_n, flash_start_r;
    logic prog_mode_r, done_seen;
    logic [1:0] flash_cmd_r, bank_busy_r;
    logic [23:0] flash_addr_r;
    logic [31:0] flash_wdata_r;
    int num_errors = 0;
    int total_checks = 0;

    fpsp_prog_model prog (.clk(clk), .program_enable_n(en_n), .device_reset_n(rst_n),
        .prog_port_select_n(sel_n), .prog_port_serial_clock(sck), .prog_port_mosi(mosi),
        .prog_port_miso(miso), .prog_port_miso_oe_n(miso_oe_n));

    fpsp_top #(.PAGE_CYCLES(SIM_CYC), .MASS_CYCLES(SIM_CYC)) DUT (.clk(clk), .reset(reset),
        .program_enable_n(en_n), .device_reset_n(rst_n), .prog_port_select_n(sel_n),
        .prog_port_serial_clock(sck), .prog_port_mosi(mosi), .prog_port_miso(miso),
        .prog_port_miso_oe_n(miso_oe_n), .flash_cmd_r(flash_cmd_r), .flash_addr_r(flash_addr_r),
        .flash_wdata_r(flash_wdata_r), .flash_start_r(flash_start_r), .flash_done(flash_done),
        .bank_busy_r(bank_busy_r), .prog_mode_r(prog_mode_r));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sel 0 start pulse, 1 banks idle, 2 mode off, 3 mode on
    task automatic wait_until(input int sel, input int lim, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clk);
            #1;
            n++;
            case (sel)
                0: hit = (flash_start_r === 1'b1);
                1: hit = (bank_busy_r === 2'h0);
                default: hit = (prog_mode_r === sel[0]);
            endcase
            if (!hit && n >= lim) begin
                num_errors++;
                $display("mismatch t=%0t got=%h exp=%h", $time, n, lim);
                give_verdict();
            end
        end
    endtask

    task automatic run_op(input logic [63:0] bits, input int nb, input logic [1:0] cmd,
                          input logic [1:0] busy, output int n);
        prog.send_frame(bits, nb);
        wait_until(0, 40, n);
        check(flash_cmd_r, cmd);
        check(bank_busy_r, busy);
        wait_until(1, SIM_CYC + 40, n);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_outside_mode();
        prog.send_frame({56'h0, 8'hc7}, 8);
        repeat (30) @(posedge clk);
        #1;
        check(prog_mode_r, 1'b0);
        check(bank_busy_r, 2'h0);
        check(miso_oe_n, 1'b1);
    endtask

    // status read during a mass erase and once idle, both after the timed-out write
    task automatic sc_status();
        int n;
        prog.send_frame({56'h0, 8'hc7}, 8);
        wait_until(0, 40, n);
        prog.send_frame({48'h0, 8'h05, 8'h00}, 16);
        check(prog.rx_bits[7:0], 8'h05);
        wait_until(1, SIM_CYC + 40, n);
        check(miso_oe_n, 1'b1);
        prog.send_frame({48'h0, 8'h05, 8'h00}, 16);
        check(prog.rx_bits[7:0], 8'h04);
    endtask

    task automatic sc_enter();
        int n;
        prog.enter_mode();
        wait_until(3, 20, n);
    endtask

    task automatic sc_write();
        int n;
        run_op({8'h02, 24'h040010, 32'hdeadbeef}, 64, FPSP_OP_WRITE, 2'h2, n);
        check(64'(n <= 527), 1'b1);
        check(flash_addr_r, 24'h040010);
    endtask

    task automatic sc_page_done();
        int n;
        prog.send_frame({32'h0, 8'h20, 24'h000800}, 32);
        wait_until(0, 40, n);
        check(flash_cmd_r, FPSP_OP_PAGE);
        check(flash_addr_r, 24'h000800);
        check(bank_busy_r, 2'h1);
        repeat (20) @(posedge clk);
        flash_done <= 1'b1;
        @(posedge clk);
        flash_done <= 1'b0;
        wait_until(1, 3, n);
    endtask

    task automatic sc_mass();
        int n;
        run_op({56'h0, 8'hc7}, 8, FPSP_OP_MASS, 2'h3, n);
        check(64'(n <= SIM_CYC + 2), 1'b1);
    endtask

    task automatic sc_leave();
        int n;
        prog.leave_mode();
        wait_until(2, 20, n);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        reset = 1'b1;
        flash_done = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        sc_outside_mode();
        sc_enter();
        sc_write();
        check(flash_wdata_r, 32'hdeadbeef);
        sc_page_done();
        sc_mass();
        sc_status();
        sc_leave();
        give_verdict();
    end
endmodule // fpsp_top_tb_top

`default_nettype wire
